// File: rtl/rfw_pkg.sv
// Shared constants and carrier types for the receive descriptor writeback engine
package rfw_pkg;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_HEAD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_CUR = 8'h0c;
	localparam logic [7:0] REG_DROP = 8'h10;

	// Control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_RESUME = 1;
	localparam int CTRL_ABORT = 2;
	localparam int CTRL_SAVE_BAD = 3;
	localparam int CTRL_LEN_CHK = 4;
	localparam int CTRL_STUFF = 5;
	localparam int CFG_W = 3;
	localparam logic [CFG_W-1:0] RST_CFG = 3'h0;
	localparam logic [31:0] RST_HEAD = 32'h0000_0000;

	// Frame descriptor word offsets
	localparam logic [31:0] OFS_CMD = 32'h0000_0000;
	localparam logic [31:0] OFS_LINK = 32'h0000_0004;
	localparam logic [31:0] OFS_RBD = 32'h0000_0008;
	localparam logic [31:0] OFS_SIZE = 32'h0000_000c;
	localparam logic [31:0] OFS_DATA = 32'h0000_001e;

	// Command and status word bits
	localparam int BIT_EL = 31;
	localparam int BIT_S = 30;
	localparam int BIT_SF = 19;
	localparam int BIT_C = 15;
	localparam int BIT_B = 14;
	localparam int BIT_OK = 13;
	localparam int BIT_LEN = 12;
	localparam int BIT_CRC = 11;
	localparam int BIT_ALN = 10;
	localparam int BIT_NORES = 9;
	localparam int BIT_OVR = 8;
	localparam int BIT_SHORT = 7;
	localparam int BIT_NOEOP = 6;
	localparam int BIT_TRUNC = 5;
	localparam int BIT_NOMATCH = 1;
	localparam int BIT_COLL = 0;

	// Size and count word fields
	localparam int CNT_W = 14;
	localparam int SIZE_LSB = 16;
	localparam int BIT_EOF = 15;
	localparam int BIT_F = 14;
	localparam logic [31:0] NO_RBD = 32'hffff_ffff;

	typedef enum logic [3:0] {
		ST_IDLE, ST_RD_CMD, ST_RD_LINK, ST_RD_RBD, ST_RD_SIZE, ST_WR_BUSY,
		ST_WAIT, ST_WR_COUNT, ST_WR_STAT, ST_SUSP, ST_END
	} rfw_st_t;

	typedef enum logic [1:0] {
		RU_IDLE, RU_READY, RU_SUSP, RU_NORES
	} rfw_ru_t;

	typedef struct packed {
		logic valid;
		logic [CNT_W-1:0] len;
		logic crc_err;
		logic aligned;
		logic too_short;
		logic overrun;
		logic no_res;
		logic no_eop;
		logic ia_match;
		logic collision;
		logic length_err;
	} rfw_frame_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} rfw_mem_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} rfw_mem_rsp_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} rfw_apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} rfw_apb_rsp_t;

	typedef struct packed {
		logic frame_ready;
		logic [31:0] desc_addr;
		logic [CNT_W-1:0] data_size;
		logic chain_en;
		logic [31:0] chain_head;
		rfw_ru_t ru_state;
	} rfw_rx_ctl_t;

endpackage

// File: rtl/rfw_status_word.sv
// Builds the completion status half-word of a frame descriptor
`timescale 1ns/1ns
`default_nettype none
module rfw_status_word (
	input wire rfw_pkg::rfw_frame_t frame,
	input wire logic save_bad,
	input wire logic len_chk,
	input wire logic stuffing,
	input wire logic flexible,
	input wire logic [rfw_pkg::CNT_W-1:0] size,
	output logic [15:0] status,
	output logic ok,
	output logic keep
);
	logic trunc;
	logic [15:0] err;

	always_comb begin
		// Only the simplified layout can overflow the descriptor itself
		trunc = !flexible && (frame.len > size);
		err = 16'h0000;
		err[rfw_pkg::BIT_LEN] = frame.length_err && len_chk; // [RULE_11]
		err[rfw_pkg::BIT_CRC] = frame.crc_err && frame.aligned; // [RULE_12]
		err[rfw_pkg::BIT_ALN] = frame.crc_err && !frame.aligned; // [RULE_13]
		err[rfw_pkg::BIT_NORES] = frame.no_res; // [RULE_14]
		err[rfw_pkg::BIT_OVR] = frame.overrun; // [RULE_15]
		err[rfw_pkg::BIT_SHORT] = frame.too_short; // [RULE_16]
		err[rfw_pkg::BIT_NOEOP] = frame.no_eop && stuffing; // [RULE_17]
		err[rfw_pkg::BIT_TRUNC] = trunc && save_bad; // [RULE_19]
		ok = (err == 16'h0000) && !trunc;
		keep = ok || save_bad; // [RULE_10]
		status = err;
		status[rfw_pkg::BIT_OK] = ok; // [RULE_09]
		status[rfw_pkg::BIT_NOMATCH] = !frame.ia_match; // [RULE_20]
		status[rfw_pkg::BIT_COLL] = frame.collision; // [RULE_21]
		// Complete set and busy cleared in the same word
		status[rfw_pkg::BIT_C] = 1'b1; // [RULE_05]
		status[rfw_pkg::BIT_B] = 1'b0; // [RULE_07]
	end
endmodule
`default_nettype wire

// File: rtl/rfw_engine.sv
// Receive frame descriptor engine: list walk, busy marking and status writeback
//
// How it works
// (RULE_01) End-of-list flag marks final descriptor of list
// (RULE_02) Suspend flag halts receive unit after frame
// (RULE_03) Select 0: data in descriptor, pointer ones
// (RULE_04) Select 1: remainder goes to buffer chain
// (RULE_05) Set complete flag when frame finished
// (RULE_06) Host writes busy flag zero before handing
// (RULE_07) Busy set at setup, cleared at completion
// (RULE_08) Complete and busy written in one write
// (RULE_09) Bit 13 set for error-free frame
// (RULE_10) Bad frames written only when saving enabled
// (RULE_11) Bit 12 length error when checking enabled
// (RULE_12) Bit 11 CRC error, byte-aligned frame
// (RULE_13) Bit 10 CRC error, misaligned frame
// (RULE_14) Bit 9 ran out of buffer space
// (RULE_15) Bit 8 overrun, bus not obtained
// (RULE_16) Bit 7 frame shorter than minimum
// (RULE_17) Bit 6 missing end marker, stuffing only
// (RULE_18) All-ones buffer pointer means no chain
// (RULE_19) Bit 5 truncation, simplified and saving only
// (RULE_20) Bit 1 clear on individual address match
// (RULE_21) Bit 0 collision after destination address
// (RULE_22) Fixed word order: status, link, pointer, size
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
module rfw_engine (
	input wire logic pclk,
	input wire logic presetn,
	input wire rfw_pkg::rfw_apb_req_t apb_req,
	output rfw_pkg::rfw_apb_rsp_t apb_rsp,
	output rfw_pkg::rfw_mem_req_t mem_req,
	input wire rfw_pkg::rfw_mem_rsp_t mem_rsp,
	input wire rfw_pkg::rfw_frame_t frame,
	output rfw_pkg::rfw_rx_ctl_t rx_ctl
);

	typedef struct packed {
		rfw_pkg::rfw_st_t st;
		logic [rfw_pkg::CFG_W-1:0] cfg;
		logic [31:0] head;
		logic [31:0] cur;
		logic [31:0] link;
		logic [31:0] buffer_descriptor;
		logic [31:0] cmd;
		logic [rfw_pkg::CNT_W-1:0] size;
		logic [15:0] stat;
		logic [rfw_pkg::CNT_W-1:0] count;
		logic [31:0] drops;
		rfw_pkg::rfw_mem_req_t mreq;
		logic [31:0] prdata;
		logic pslverr;
	} rfw_state_t;

	rfw_state_t s;
	rfw_state_t next_s;

	logic [15:0] frame_stat;
	logic frame_ok;
	logic frame_keep;
	logic flexible;
	logic setup;
	logic wr_acc;
	logic known;
	logic start;
	logic resume;
	logic abort;
	logic acked;
	rfw_pkg::rfw_ru_t ru;

	assign flexible = s.cmd[rfw_pkg::BIT_SF];

	rfw_status_word u_status (
		.frame(frame),
		.save_bad(s.cfg[0]),
		.len_chk(s.cfg[1]),
		.stuffing(s.cfg[2]),
		.flexible(flexible),
		.size(s.size),
		.status(frame_stat),
		.ok(frame_ok),
		.keep(frame_keep)
	);

	always_comb begin
		unique case (s.st)
			rfw_pkg::ST_IDLE: ru = rfw_pkg::RU_IDLE;
			rfw_pkg::ST_SUSP: ru = rfw_pkg::RU_SUSP;
			rfw_pkg::ST_END: ru = rfw_pkg::RU_NORES;
			default: ru = rfw_pkg::RU_READY;
		endcase
	end

	always_comb begin
		setup = apb_req.psel && !apb_req.penable;
		wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
		known = (apb_req.paddr == rfw_pkg::REG_CTRL) || (apb_req.paddr == rfw_pkg::REG_HEAD) ||
			(apb_req.paddr == rfw_pkg::REG_STAT) || (apb_req.paddr == rfw_pkg::REG_CUR) ||
			(apb_req.paddr == rfw_pkg::REG_DROP);
		start = wr_acc && (apb_req.paddr == rfw_pkg::REG_CTRL) && apb_req.pwdata[rfw_pkg::CTRL_START];
		resume = wr_acc && (apb_req.paddr == rfw_pkg::REG_CTRL) && apb_req.pwdata[rfw_pkg::CTRL_RESUME];
		abort = wr_acc && (apb_req.paddr == rfw_pkg::REG_CTRL) && apb_req.pwdata[rfw_pkg::CTRL_ABORT];
		acked = s.mreq.req && mem_rsp.ack;
	end

	always_comb begin
		next_s = s;

		// Register answers are prepared in the setup phase so read data comes from a flop
		if (setup) begin
			next_s.pslverr = !known;
			next_s.prdata = 32'h0000_0000;
			unique case (apb_req.paddr)
				rfw_pkg::REG_CTRL: next_s.prdata[rfw_pkg::CTRL_STUFF:rfw_pkg::CTRL_SAVE_BAD] = s.cfg;
				rfw_pkg::REG_HEAD: next_s.prdata = s.head;
				rfw_pkg::REG_STAT: begin
					next_s.prdata[1:0] = ru;
					next_s.prdata[7:4] = s.st;
					next_s.prdata[31:16] = s.stat;
				end
				rfw_pkg::REG_CUR: next_s.prdata = s.cur;
				rfw_pkg::REG_DROP: next_s.prdata = s.drops;
				default: next_s.prdata = 32'h0000_0000;
			endcase
		end
		if (wr_acc && apb_req.paddr == rfw_pkg::REG_CTRL) begin
			next_s.cfg = apb_req.pwdata[rfw_pkg::CTRL_STUFF:rfw_pkg::CTRL_SAVE_BAD];
		end
		if (wr_acc && apb_req.paddr == rfw_pkg::REG_HEAD) begin
			next_s.head = apb_req.pwdata;
		end
		if (wr_acc && apb_req.paddr == rfw_pkg::REG_DROP) begin
			next_s.drops = 32'h0000_0000;
		end

		unique case (s.st)
			rfw_pkg::ST_IDLE, rfw_pkg::ST_END: begin
				if (start) begin
					next_s.cur = s.head;
					next_s.st = rfw_pkg::ST_RD_CMD;
					next_s.mreq.req = 1'b1;
					next_s.mreq.we = 1'b0;
					next_s.mreq.addr = s.head + rfw_pkg::OFS_CMD; // [RULE_22]
				end
			end
			rfw_pkg::ST_RD_CMD: begin
				if (acked) begin
					// Host left busy at zero; this copy is what we rewrite later
					next_s.cmd = mem_rsp.rdata; // [RULE_06]
					next_s.st = rfw_pkg::ST_RD_LINK;
					next_s.mreq.addr = s.cur + rfw_pkg::OFS_LINK; // [RULE_22]
				end
			end
			rfw_pkg::ST_RD_LINK: begin
				if (acked) begin
					next_s.link = mem_rsp.rdata;
					next_s.st = rfw_pkg::ST_RD_RBD;
					next_s.mreq.addr = s.cur + rfw_pkg::OFS_RBD; // [RULE_22]
				end
			end
			rfw_pkg::ST_RD_RBD: begin
				if (acked) begin
					next_s.buffer_descriptor = mem_rsp.rdata;
					next_s.st = rfw_pkg::ST_RD_SIZE;
					next_s.mreq.addr = s.cur + rfw_pkg::OFS_SIZE; // [RULE_22]
				end
			end
			rfw_pkg::ST_RD_SIZE: begin
				if (acked) begin
					next_s.size = mem_rsp.rdata[rfw_pkg::SIZE_LSB +: rfw_pkg::CNT_W];
					next_s.st = rfw_pkg::ST_WR_BUSY;
					next_s.mreq.we = 1'b1;
					next_s.mreq.addr = s.cur + rfw_pkg::OFS_CMD;
					next_s.mreq.wdata = s.cmd;
					next_s.mreq.wdata[rfw_pkg::BIT_B] = 1'b1; // [RULE_07]
					next_s.mreq.wdata[rfw_pkg::BIT_C] = 1'b0;
				end
			end
			rfw_pkg::ST_WR_BUSY: begin
				if (acked) begin
					next_s.mreq.req = 1'b0;
					next_s.mreq.we = 1'b0;
					next_s.st = rfw_pkg::ST_WAIT;
				end
			end
			rfw_pkg::ST_WAIT: begin
				if (abort) begin
					next_s.st = rfw_pkg::ST_IDLE;
				end else if (frame.valid) begin
					if (frame_keep) begin // [RULE_10]
						next_s.stat = frame_stat;
						// Only what fits the descriptor is counted here; with chain_en set the chain holds the rest
						next_s.count = (frame.len > s.size) ? s.size : frame.len; // [RULE_03] [RULE_04]
						next_s.st = rfw_pkg::ST_WR_COUNT;
						next_s.mreq.req = 1'b1;
						next_s.mreq.we = 1'b1;
						next_s.mreq.addr = s.cur + rfw_pkg::OFS_SIZE;
						next_s.mreq.wdata = 32'h0000_0000;
						next_s.mreq.wdata[rfw_pkg::SIZE_LSB +: rfw_pkg::CNT_W] = s.size;
						next_s.mreq.wdata[rfw_pkg::BIT_EOF] = 1'b1;
						next_s.mreq.wdata[rfw_pkg::BIT_F] = 1'b1;
						next_s.mreq.wdata[rfw_pkg::CNT_W-1:0] = next_s.count;
					end else begin
						// Discarded frame: same descriptor stays armed, only the drop count and, for a truncated frame, the status move
						// Counts on top of a same-cycle clear so no drop is lost
						next_s.drops = next_s.drops + 32'h0000_0001; // [RULE_10]
						if (!frame_ok && frame.len > s.size && !flexible) begin
							next_s.stat = frame_stat;
						end
					end
				end
			end
			rfw_pkg::ST_WR_COUNT: begin
				if (acked) begin
					next_s.st = rfw_pkg::ST_WR_STAT;
					next_s.mreq.addr = s.cur + rfw_pkg::OFS_CMD;
					// One write carries complete, busy and all status bits together
					next_s.mreq.wdata = {s.cmd[31:16], s.stat}; // [RULE_08] [RULE_05] [RULE_07]
				end
			end
			rfw_pkg::ST_WR_STAT: begin
				if (acked) begin
					next_s.mreq.req = 1'b0;
					next_s.mreq.we = 1'b0;
					if (s.cmd[rfw_pkg::BIT_S]) begin
						next_s.st = rfw_pkg::ST_SUSP; // [RULE_02]
					end else if (s.cmd[rfw_pkg::BIT_EL]) begin
						next_s.st = rfw_pkg::ST_END; // [RULE_01]
					end else begin
						next_s.cur = s.link;
						next_s.st = rfw_pkg::ST_RD_CMD;
						next_s.mreq.req = 1'b1;
						next_s.mreq.addr = s.link + rfw_pkg::OFS_CMD;
					end
				end
			end
			rfw_pkg::ST_SUSP: begin
				if (start) begin
					next_s.cur = s.head;
					next_s.st = rfw_pkg::ST_RD_CMD;
					next_s.mreq.req = 1'b1;
					next_s.mreq.addr = s.head + rfw_pkg::OFS_CMD;
				end else if (resume) begin
					// A suspended last entry has nothing after it to resume into
					if (s.cmd[rfw_pkg::BIT_EL]) begin
						next_s.st = rfw_pkg::ST_END; // [RULE_01]
					end else begin
						next_s.cur = s.link;
						next_s.st = rfw_pkg::ST_RD_CMD;
						next_s.mreq.req = 1'b1;
						next_s.mreq.addr = s.link + rfw_pkg::OFS_CMD;
					end
				end else if (abort) begin
					next_s.st = rfw_pkg::ST_IDLE;
				end
			end
			// Unused encodings fall back to idle with the bus released
			default: begin
				next_s.st = rfw_pkg::ST_IDLE;
				next_s.mreq = '0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.st <= rfw_pkg::ST_IDLE;
			s.cfg <= rfw_pkg::RST_CFG;
			s.head <= rfw_pkg::RST_HEAD;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		apb_rsp.pready = 1'b1;
		apb_rsp.prdata = s.prdata;
		apb_rsp.pslverr = s.pslverr && apb_req.psel && apb_req.penable;
		mem_req = s.mreq;
		rx_ctl.frame_ready = (s.st == rfw_pkg::ST_WAIT);
		rx_ctl.desc_addr = s.cur;
		rx_ctl.data_size = s.size;
		// Chain only in flexible layout and only when a real pointer is attached
		rx_ctl.chain_en = flexible && (s.buffer_descriptor != rfw_pkg::NO_RBD); // [RULE_04] [RULE_18] [RULE_03]
		rx_ctl.chain_head = s.buffer_descriptor;
		rx_ctl.ru_state = ru;
	end

endmodule
`default_nettype wire

// File: test/rfw_checker.sv
// Concurrent checks on the descriptor engine ports
`timescale 1ns/1ns
`default_nettype none
module rfw_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire rfw_pkg::rfw_mem_req_t mem_req,
	input wire rfw_pkg::rfw_mem_rsp_t mem_rsp,
	input wire rfw_pkg::rfw_frame_t frame,
	input wire rfw_pkg::rfw_rx_ctl_t rx_ctl
);
	rfw_pkg::rfw_frame_t fq;
	logic wr0;
	logic sw;
	logic bw;
	assign wr0 = mem_req.req && mem_req.we && mem_rsp.ack && mem_req.addr == rx_ctl.desc_addr;
	assign sw = wr0 && mem_req.wdata[15];
	assign bw = wr0 && mem_req.wdata[14];
	// Qualifiers of the accepted frame, compared at status writeback
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) fq <= '0;
		else if (frame.valid && rx_ctl.frame_ready) fq <= frame;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_one_write; wr0 |-> mem_req.wdata[15] != mem_req.wdata[14]; endproperty
	a_one_write: assert property (p_one_write) else $error("complete and busy mixed");
	property p_busy_arms; bw |=> ##[0:2] rx_ctl.frame_ready; endproperty
	a_busy_arms: assert property (p_busy_arms) else $error("not armed after busy");
	property p_ok; sw && mem_req.wdata[13] |-> mem_req.wdata[12:5] == 8'h00; endproperty
	a_ok: assert property (p_ok) else $error("success with error bits");
	property p_crc; sw |-> mem_req.wdata[11] == (fq.crc_err && fq.aligned); endproperty
	a_crc: assert property (p_crc) else $error("crc bit wrong");
	property p_aln; sw |-> mem_req.wdata[10] == (fq.crc_err && !fq.aligned); endproperty
	a_aln: assert property (p_aln) else $error("alignment bit wrong");
	property p_res; sw |-> mem_req.wdata[9:7] == {fq.no_res, fq.overrun, fq.too_short}; endproperty
	a_res: assert property (p_res) else $error("resource bits wrong");
	property p_match; sw |-> mem_req.wdata[1:0] == {!fq.ia_match, fq.collision}; endproperty
	a_match: assert property (p_match) else $error("match bits wrong");
	property p_susp; sw && mem_req.wdata[30] |=> ##[0:2] rx_ctl.ru_state == rfw_pkg::RU_SUSP; endproperty
	a_susp: assert property (p_susp) else $error("no suspend");
	property p_end;
		sw && mem_req.wdata[31] && !mem_req.wdata[30] |=> ##[0:2] rx_ctl.ru_state == rfw_pkg::RU_NORES;
	endproperty
	a_end: assert property (p_end) else $error("list end missed");
	property p_nochain; rx_ctl.chain_head == rfw_pkg::NO_RBD |-> !rx_ctl.chain_en; endproperty
	a_nochain: assert property (p_nochain) else $error("chain on empty pointer");
	c_status: cover property (sw);
	c_susp: cover property (sw && mem_req.wdata[30]);
	c_chain: cover property (rx_ctl.chain_en && rx_ctl.frame_ready);
endmodule
bind rfw_engine rfw_checker chk (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_rsp(mem_rsp),
	.frame(frame), .rx_ctl(rx_ctl));
`default_nettype wire

// File: test/rfw_mem_model.sv
// System memory model answering descriptor word accesses
`timescale 1ns/1ns
`default_nettype none
module rfw_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire rfw_pkg::rfw_mem_req_t mem_req,
	output rfw_pkg::rfw_mem_rsp_t mem_rsp
);
	logic [31:0] m [0:63];
	logic [1:0] wait_cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_rsp <= '0;
			wait_cnt <= '0;
		end else begin
			mem_rsp.ack <= 1'b0;
			// Released data bus inverts its last word every cycle, so that word returns every second cycle
			mem_rsp.rdata <= ~mem_rsp.rdata;
			if (mem_req.req && !mem_rsp.ack) begin
				if (slow && wait_cnt != 2'h2) begin
					wait_cnt <= wait_cnt + 2'h1;
				end else begin
					wait_cnt <= '0;
					mem_rsp.ack <= 1'b1;
					if (mem_req.we) m[mem_req.addr[7:2]] <= mem_req.wdata;
					else mem_rsp.rdata <= m[mem_req.addr[7:2]];
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Directed bench for the descriptor writeback engine
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic pclk;
	logic presetn;
	logic slow;
	rfw_pkg::rfw_apb_req_t apb_req;
	rfw_pkg::rfw_apb_rsp_t apb_rsp;
	rfw_pkg::rfw_mem_req_t mem_req;
	rfw_pkg::rfw_mem_rsp_t mem_rsp;
	rfw_pkg::rfw_frame_t frame;
	rfw_pkg::rfw_rx_ctl_t rx_ctl;
	int fail_count;
	int num_checks;
	int cyc;
	logic [31:0] rd;
	logic err;
	rfw_engine dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.mem_req(mem_req), .mem_rsp(mem_rsp), .frame(frame), .rx_ctl(rx_ctl));
	rfw_mem_model mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req), .mem_rsp(mem_rsp));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb_req <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask
	task desc(input int i, input logic [31:0] c, input logic [31:0] l, input logic [31:0] b, input logic [31:0] s);
		mem.m[i] = c;
		mem.m[i+1] = l;
		mem.m[i+2] = b;
		mem.m[i+3] = s;
	endtask
	// Waits until a descriptor is armed; a missing arm counts as a mismatch
	task arm;
		int k;
		k = 0;
		while (rx_ctl.frame_ready !== 1'b1 && k < 300) begin
			@(posedge pclk);
			k++;
		end
		chk("frame_ready", 32'h1, {31'h0, rx_ctl.frame_ready});
	endtask
	// Waits for arming, offers one frame, then waits for its writeback
	task rx(input logic [13:0] n, input logic [8:0] q, input int w);
		int k;
		arm;
		chk("busy", 32'h4000, {16'h0, mem.m[w][15:0]});
		frame <= {1'b1, n, q};
		@(posedge pclk);
		frame.valid <= 1'b0;
		k = 0;
		while (mem.m[w][15] !== 1'b1 && k < 60) begin
			@(posedge pclk);
			k++;
		end
	endtask
	task done(input int w, input logic [31:0] s, input logic [31:0] c);
		chk("status", s, mem.m[w]);
		chk("count", c, mem.m[w+3]);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			report_and_stop;
		end
	end
	initial begin
		frame = '0;
		apb_req = '0;
		slow = 1'b0;
		presetn = 1'b0;
		desc(0, 32'h0008_0000, 32'h20, rfw_pkg::NO_RBD, 32'h0040_0000);
		desc(8, 32'h4000_0000, 32'h40, rfw_pkg::NO_RBD, 32'h0010_0000);
		desc(16, 32'h8008_0000, 32'h0, 32'h100, 32'h0008_0000);
		desc(24, 32'h8000_0000, 32'h0, rfw_pkg::NO_RBD, 32'h0010_0000);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, rfw_pkg::REG_HEAD, 32'h0);
		apb(1'b1, rfw_pkg::REG_CTRL, 32'h39);
		rx(14'd40, 9'h004, 0);
		done(0, 32'h0008_a000, 32'h0040_c028);
		chk("chain_en", 32'h0, {31'h0, rx_ctl.chain_en});
		rx(14'd20, 9'h1fb, 8);
		done(8, 32'h4000_9be3, 32'h0010_c010);
		chk("chain_en", 32'h0, {31'h0, rx_ctl.chain_en});
		apb(1'b0, rfw_pkg::REG_STAT, 32'h0);
		chk("ru", 32'h2, {30'h0, rd[1:0]});
		slow <= 1'b1;
		apb(1'b1, rfw_pkg::REG_CTRL, 32'h3a);
		rx(14'd30, 9'h104, 16);
		chk("chain_en", 32'h1, {31'h0, rx_ctl.chain_en});
		chk("chain_head", 32'h100, rx_ctl.chain_head);
		done(16, 32'h8008_8400, 32'h0008_c008);
		apb(1'b0, rfw_pkg::REG_STAT, 32'h0);
		chk("ru", 32'h3, {30'h0, rd[1:0]});
		apb(1'b1, rfw_pkg::REG_HEAD, 32'h60);
		apb(1'b1, rfw_pkg::REG_CTRL, 32'h1);
		rx(14'd10, 9'h184, 24);
		rx(14'd20, 9'h084, 24);
		apb(1'b0, rfw_pkg::REG_DROP, 32'h0);
		chk("drops", 32'h2, rd);
		rx(14'd12, 9'h00d, 24);
		done(24, 32'h8000_a000, 32'h0010_c00c);
		// Restart on the finished list, look at the armed descriptor, then abort
		apb(1'b1, rfw_pkg::REG_CTRL, 32'h21);
		arm;
		chk("desc_addr", 32'h60, rx_ctl.desc_addr);
		chk("data_size", 32'h10, {18'h0, rx_ctl.data_size});
		apb(1'b0, rfw_pkg::REG_CUR, 32'h0);
		chk("cur", 32'h60, rd);
		apb(1'b0, rfw_pkg::REG_HEAD, 32'h0);
		chk("head", 32'h60, rd);
		apb(1'b0, rfw_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 32'h20, rd);
		chk("slverr", 32'h0, {31'h0, err});
		apb(1'b1, rfw_pkg::REG_CTRL, 32'h4);
		apb(1'b0, rfw_pkg::REG_STAT, 32'h0);
		chk("stat", 32'ha000_0000, rd);
		report_and_stop;
	end
endmodule
`default_nettype wire
